/* File: rsf_pkg.sv */
// Shared constants for the rotate-right and set-file execution block
package rsf_pkg;
  // Opcode layout
  localparam logic [5:0] ROT_OPC = 6'h10;
  localparam int ROT_OPC_HI = 15;
  localparam int ROT_OPC_LO = 10;
  localparam logic [6:0] SET_OPC = 7'h34;
  localparam int SET_OPC_HI = 15;
  localparam int SET_OPC_LO = 9;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int FADDR_HI = 7;
  localparam int FADDR_LO = 0;
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  // Addressing constants and the set-file data value
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;
  // Phase sequencer
  typedef enum logic [2:0] {
    RSF_IDLE,
    RSF_Q1,
    RSF_Q2,
    RSF_Q3,
    RSF_Q4
  } rsf_phase_t;
endpackage

/* File: rsf_exec.sv */
// Function
// - Right-rotate op decoded from pattern 0100 00da plus 8-bit file address.
// - Rotate right one place, bit 0 goes to bit 7, carry untouched.
// - d=0 writes working register; d=1 writes back to file register.
// - a=0 addresses the access bank, bank select register ignored.
// - a=1 forms address from bank select register and file address.
// - a=0, extended set on, address up to 95 uses indexed literal offset.
// - File address is 8 bits, reaching 0 through 255 in the bank.
// - Right-rotate op is one word and one instruction cycle.
// - Set-file op writes FFh to the file register, banked like others.
`timescale 1ns/1ps
`default_nettype none
module rsf_exec (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [3:0] i_bank_select,
  input wire logic i_ext_set_en,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0] i_mem_rdata,
  output logic o_ready,
  output logic o_accept,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [11:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_wreg_wr,
  output logic [7:0] o_wreg_data,
  output logic o_done
);

  // Operand address for a byte-oriented access
  function automatic logic [11:0] f_addr(input logic bank_bit,
                                         input logic ext_en,
                                         input logic [7:0] fa,
                                         input logic [3:0] bank_select_register,
                                         input logic [11:0] base);
    logic [11:0] a;
    a = {bank_select_register, fa};
    if (!bank_bit) begin
      if (ext_en && fa <= rsf_pkg::IDX_LIMIT)
        a = base + {4'h0, fa};
      else if (fa < rsf_pkg::ACC_SPLIT)
        a = {rsf_pkg::ACC_LO_BANK, fa};
      else
        a = {rsf_pkg::ACC_HI_BANK, fa};
    end
    return a;
  endfunction

  rsf_pkg::rsf_phase_t phase_ff, nxt_phase;
  logic [15:0] instr_ff;
  logic is_set_ff;
  logic [11:0] addr_ff;
  logic [7:0] rdata_ff;
  logic [7:0] result_ff;

  // Opcode recognition
  wire logic is_rot;
  wire logic is_set;
  wire logic take;
  assign is_rot = i_instr[rsf_pkg::ROT_OPC_HI:rsf_pkg::ROT_OPC_LO]
                  == rsf_pkg::ROT_OPC;
  assign is_set = i_instr[rsf_pkg::SET_OPC_HI:rsf_pkg::SET_OPC_LO]
                  == rsf_pkg::SET_OPC;
  assign o_ready = (phase_ff == rsf_pkg::RSF_IDLE);
  // Unknown opcodes are dropped so other units may own them
  assign take = i_instr_valid && o_ready && (is_rot || is_set);
  assign o_accept = take;

  // Destination bit only exists for the rotate; set-file always hits file
  wire logic to_wreg;
  assign to_wreg = !is_set_ff && !instr_ff[rsf_pkg::DEST_BIT];

  wire logic [7:0] faddr;
  assign faddr = instr_ff[rsf_pkg::FADDR_HI:rsf_pkg::FADDR_LO];

  wire logic [11:0] op_addr;
  assign op_addr = f_addr(instr_ff[rsf_pkg::BANK_BIT], i_ext_set_en,
                          faddr, i_bank_select, i_index_base);

  wire logic [7:0] rot_val;
  assign rot_val = {rdata_ff[0], rdata_ff[7:1]};

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      rsf_pkg::RSF_IDLE: if (take) nxt_phase = rsf_pkg::RSF_Q1;
      rsf_pkg::RSF_Q1: nxt_phase = rsf_pkg::RSF_Q2;
      rsf_pkg::RSF_Q2: nxt_phase = rsf_pkg::RSF_Q3;
      rsf_pkg::RSF_Q3: nxt_phase = rsf_pkg::RSF_Q4;
      rsf_pkg::RSF_Q4: nxt_phase = rsf_pkg::RSF_IDLE;
      default: nxt_phase = rsf_pkg::RSF_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      phase_ff <= rsf_pkg::RSF_IDLE;
    else
      phase_ff <= nxt_phase;
  end

  // Instruction latch
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      instr_ff <= 16'h0000;
      is_set_ff <= 1'b0;
    end else if (take) begin
      instr_ff <= i_instr;
      is_set_ff <= is_set;
    end
  end

  // Address fixed in Q1 so bank register changes mid-cycle cannot move it
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      addr_ff <= rsf_pkg::ADDR_RST;
    else if (phase_ff == rsf_pkg::RSF_Q1)
      addr_ff <= op_addr;
  end

  // Read in Q2
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      rdata_ff <= rsf_pkg::DATA_RST;
    else if (phase_ff == rsf_pkg::RSF_Q2)
      rdata_ff <= i_mem_rdata;
  end

  // Process in Q3
  // all ones result for set-file, rotated byte for the rotate
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      result_ff <= rsf_pkg::DATA_RST;
    else if (phase_ff == rsf_pkg::RSF_Q3)
      result_ff <= is_set_ff ? rsf_pkg::ALL_ONES : rot_val;
  end

  wire logic in_q4;
  assign in_q4 = (phase_ff == rsf_pkg::RSF_Q4);
  assign o_mem_rd = (phase_ff == rsf_pkg::RSF_Q2);
  assign o_mem_wr = in_q4 && !to_wreg;
  assign o_wreg_wr = in_q4 && to_wreg;
  assign o_done = in_q4;
  assign o_mem_addr = addr_ff;
  assign o_mem_wdata = result_ff;
  assign o_wreg_data = result_ff;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_start;
    o_accept;
  endsequence
  sequence s_walk;
    ##1 phase_ff == rsf_pkg::RSF_Q1 ##1 o_mem_rd ##1 !o_mem_rd ##1 o_done;
  endsequence

  property p_rot_decode;
    i_instr_valid && o_ready && i_instr[15:10] == 6'h10 |-> o_accept;
  endproperty
  a_rot_decode: assert property (p_rot_decode)
    else $error("rotate opcode not taken");

  property p_rot_value;
    o_accept && is_rot ##2 o_mem_rd |->
      ##2 o_done && (result_ff == (({$past(i_mem_rdata, 2)} >> 1)
      | {$past(i_mem_rdata[0], 2), 7'h00}));
  endproperty
  a_rot_value: assert property (p_rot_value)
    else $error("rotate result wrong");

  property p_dest_w;
    o_accept && is_rot && !i_instr[9] |-> ##4 o_wreg_wr && !o_mem_wr;
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("working register not written");

  property p_dest_f;
    o_accept && i_instr[9] |-> ##4 o_mem_wr && !o_wreg_wr;
  endproperty
  a_dest_f: assert property (p_dest_f)
    else $error("file register not written");

  property p_access;
    o_accept && !i_instr[8] && !i_ext_set_en ##1 !i_ext_set_en |->
      ##1 o_mem_addr[7:0] == $past(i_instr[7:0], 2) &&
      o_mem_addr[11:8] == (o_mem_addr[7:0] < 8'h60 ? 4'h0 : 4'hF);
  endproperty
  a_access: assert property (p_access)
    else $error("access bank address wrong");

  property p_banked;
    o_accept && i_instr[8] |->
      ##2 o_mem_addr == {$past(i_bank_select), $past(i_instr[7:0], 2)};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");

  property p_indexed;
    o_accept && !i_instr[8] && i_instr[7:0] <= 8'h5F ##1 i_ext_set_en |->
      ##1 o_mem_addr == $past(i_index_base) + {4'h0, $past(i_instr[7:0], 2)};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal address wrong");

  property p_one_cycle;
    s_start |-> s_walk ##1 o_ready;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("phase walk not four steps");

  property p_set_ones;
    o_accept && is_set |-> ##4 o_mem_wr && o_mem_wdata == 8'hFF;
  endproperty
  a_set_ones: assert property (p_set_ones)
    else $error("set-file did not write all ones");

  property p_write_q4;
    (o_mem_wr || o_wreg_wr) |-> $past(phase_ff) == rsf_pkg::RSF_Q3;
  endproperty
  a_write_q4: assert property (p_write_q4)
    else $error("write outside last phase");

endmodule
`default_nettype wire

/* File: rsf_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsf_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [11:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic i_load,
  input wire logic [11:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  output logic [7:0] o_mem_rdata
);
  logic [7:0] mem [0:4095];
  logic tick_ff;
  // Off-read data keeps changing so a late sample never looks valid
  assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : {4'hA, {4{tick_ff}}};
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
      // Preload goes through a port so only this process writes the array
      if (i_load) begin
        mem[i_load_addr] <= i_load_data;
      end else if (i_mem_wr) begin
        mem[i_mem_addr] <= i_mem_wdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic ext = 1'b0;
  logic [11:0] base = 12'h123;
  logic load = 1'b0;
  logic [11:0] load_addr = 12'h000;
  logic [7:0] load_data = 8'h00;
  logic [7:0] rdata;
  logic rdy, acc, mrd, mwr, wwr, done;
  logic [11:0] addr;
  logic [7:0] wdata, wreg;
  int errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  rsf_exec DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_instr_valid(valid),
    .i_instr(instr), .i_bank_select(bank_select_register), .i_ext_set_en(ext),
    .i_index_base(base), .i_mem_rdata(rdata), .o_ready(rdy),
    .o_accept(acc), .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_addr(addr),
    .o_mem_wdata(wdata), .o_wreg_wr(wwr), .o_wreg_data(wreg),
    .o_done(done));
  rsf_mem_model mem (.i_ref_clk(clk), .i_resetn(rstn), .i_mem_rd(mrd),
    .i_mem_wr(mwr), .i_mem_addr(addr), .i_mem_wdata(wdata),
    .i_load(load), .i_load_addr(load_addr), .i_load_data(load_data),
    .o_mem_rdata(rdata));
  task automatic wrap_up();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Issue one instruction and judge its single cycle of four phases
  task automatic run(input logic [15:0] ins, input logic [3:0] bs,
      input logic ex, input logic [11:0] ea, input logic [7:0] d,
      input logic to_w, input logic is_set);
    int n;
    logic [7:0] exp;
    exp = is_set ? 8'hFF : {d[0], d[7:1]};
    @(posedge clk);
    valid <= 1'b1;
    instr <= ins;
    bank_select_register <= bs;
    ext <= ex;
    load <= 1'b1;
    load_addr <= ea;
    load_data <= d;
    #1 `CHK(acc, 1'b1)
    @(posedge clk);
    // Offer stays up for one busy cycle and must be ignored
    load <= 1'b0;
    #1 n = 1;
    while (done !== 1'b1) begin
      `CHK(mwr | wwr, 1'b0)
      `CHK(mrd, n == 2)
      `CHK(acc, 1'b0)
      @(posedge clk);
      valid <= 1'b0;
      #1 n++;
      if (n > 10) begin
        errors++;
        wrap_up();
      end
    end
    `CHK(n, 4)
    `CHK(addr, ea)
    `CHK(wwr, to_w)
    `CHK(mwr, !to_w)
    `CHK(to_w ? wreg : wdata, exp)
    @(posedge clk);
    #1 `CHK(rdy, 1'b1)
    `CHK(mem.mem[ea], to_w ? d : exp)
  endtask
  // An opcode of neither kind must never be taken
  task automatic refuse();
    @(posedge clk);
    valid <= 1'b1;
    instr <= 16'h0003;
    #1 `CHK(acc, 1'b0)
    @(posedge clk);
    valid <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    run(16'h43FF, 4'h3, 1'b0, 12'h3FF, 8'hD7, 1'b0, 1'b0);
    run(16'h4060, 4'h7, 1'b1, 12'hF60, 8'h01, 1'b1, 1'b0);
    run(16'h425F, 4'h7, 1'b1, 12'h182, 8'h80, 1'b0, 1'b0);
    run(16'h4205, 4'h7, 1'b0, 12'h005, 8'h6C, 1'b0, 1'b0);
    run(16'h6910, 4'h2, 1'b0, 12'h210, 8'h5A, 1'b0, 1'b1);
    run(16'h685F, 4'h2, 1'b1, 12'h182, 8'h00, 1'b0, 1'b1);
    refuse();
    wrap_up();
  end
endmodule
`default_nettype wire
